// File: pulse_link_ports.sv
// two-port reversible pulse link with four-wire spi front end
// assumes pins are asynchronous and the core logic shares core_clk_in
// How it works
// RULE1: second port is always a pulse port
// RULE2: four-wire strap makes first port the target
// RULE3: host starts transactions on first device
// RULE4: start on first port makes it target
// RULE5: start on second port reverses direction
// RULE6: break bit silences the controller port
// RULE7: break bit still lets commands be answered
// RULE8: watchdog reset clears the break bit
// RULE9: host clears break bits to find faults
// RULE10: transmitter drives positive, negative or off
// RULE11: symbol is two opposite halves then off
// RULE12: both halves equal, symbol twice half
// RULE13: long halves 150 ns, short 50 ns
// RULE14: spi front end finds four events
// RULE15: events map to long or short symbols
// RULE16: long symbols set internal chip select
// RULE17: short symbols set data, pulse clock
// RULE18: target replies only during reads
// RULE19: target never sends long symbols
// RULE20: missing reply reads as logic one
// RULE21: strap low selects four-wire first port
// RULE22: host keeps data stable at clock rise
// RULE23: first half width classifies long or short
`timescale 1ns/1ns
`include "pulse_link_map.svh"
module pulse_link_ports (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic clk_en_in,
  input wire logic port_a_mode_strap_in,
  input wire logic chip_select_n_in,
  input wire logic spi_clk_in,
  input wire logic serial_data_in_in,
  input wire logic first_port_pos_pin_in,
  output logic first_port_pos_pin_out,
  output logic first_port_pos_pin_oe_out,
  input wire logic first_port_neg_pin_in,
  output logic first_port_neg_pin_out,
  output logic first_port_neg_pin_oe_out,
  input wire logic second_port_pos_pin_in,
  output logic second_port_pos_pin_out,
  output logic second_port_pos_pin_oe_out,
  input wire logic second_port_neg_pin_in,
  output logic second_port_neg_pin_out,
  output logic second_port_neg_pin_oe_out,
  input wire logic core_read_active_in,
  input wire logic core_read_bit_in,
  input wire logic break_write_in,
  input wire logic break_value_in,
  input wire logic watchdog_reset_in,
  output logic core_cs_n_out,
  output logic core_sck_out,
  output logic core_sdi_out,
  output logic chain_break_enable_out,
  output logic return_valid_out,
  output logic return_bit_out,
  output logic port_b_target_out
);
  // widths of the timing counts as met by the 8-bit counters
  localparam logic [7:0] LONG_HALF = 8'(`LONG_HALF_CYC);
  localparam logic [7:0] SHORT_HALF = 8'(`SHORT_HALF_CYC);
  localparam logic [7:0] THRESH = 8'(`CLASS_THRESH_CYC);
  localparam logic [7:0] SLOT = 8'(`SLOT_CYC);

  logic [1:0] rst_q; // reset release stages
  logic rst_n; // synchronised reset
  logic [7:0] raw; // asynchronous inputs
  logic [7:0] sync1; // first stage, read only by sync2
  logic [7:0] sync2; // safe copies
  logic cs_d; // delayed chip select for edges
  logic sck_d; // delayed spi clock for edges
  logic four_wire; // first port is a four-wire spi
  logic next_dir_b; // next direction
  logic slot_load; // controller opens a reply slot
  logic [7:0] slot_cnt; // cycles left in the reply slot
  logic [7:0] on_len; // helper: cycles port b has driven
  pulse_link_pkg::sym_t spi_ev; // event from the spi front end
  pulse_link_pkg::sym_t tgt_ev; // event seen on the target side
  pulse_link_pkg::sym_t tx_req [2]; // symbol requests per port
  pulse_link_pkg::sym_t rx_sym [2]; // decoded symbols per port
  logic tx_on [2]; // pins driven
  logic tx_pos [2]; // positive pin sources
  logic tx_neg [2]; // negative pin sources
  logic tx_long [2]; // current symbol is long
  logic tgt; // index of the target port
  logic ctl; // index of the controller port

  // reset is released through two flip-flops
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // pins: strap, cs, sck, sdi, then pos/neg of each port
  assign raw = {second_port_neg_pin_in, second_port_pos_pin_in,
                first_port_neg_pin_in, first_port_pos_pin_in,
                serial_data_in_in, spi_clk_in, chip_select_n_in,
                port_a_mode_strap_in};

  // two-stage synchronisers, plus a third stage for edge finding
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= 8'h02;
      sync2 <= 8'h02;
      cs_d <= 1'b1;
      sck_d <= 1'b0;
    end else if (clk_en_in) begin
      sync1 <= raw;
      sync2 <= sync1;
      cs_d <= sync2[1];
      sck_d <= sync2[2];
    end
  end

  // RULE21 strap decode
  assign four_wire = (sync2[0] == `MODE_FOUR_WIRE);

  // spi front end events, only while the strap selects it
  always_comb begin
    spi_ev = '0;
    if (four_wire) begin
      // RULE14 RULE15 event to symbol
      if (!sync2[1] && cs_d) begin
        spi_ev = '{1'b1, 1'b1, 1'b0};
      end else if (sync2[1] && !cs_d) begin
        spi_ev = '{1'b1, 1'b1, 1'b1};
      end else if (sync2[2] && !sck_d && !sync2[1]) begin
        spi_ev = '{1'b1, 1'b0, sync2[3]};
      end
    end
  end

  // port direction follows where an idle transaction starts
  always_comb begin
    next_dir_b = port_b_target_out;
    if (four_wire) begin
      // RULE2 fixed direction
      next_dir_b = 1'b0;
    end else if (core_cs_n_out && rx_sym[0].valid) begin
      // RULE4 first port starts
      next_dir_b = 1'b0;
    end else if (core_cs_n_out && rx_sym[1].valid) begin
      // RULE5 reverse the chain
      next_dir_b = 1'b1;
    end
  end
  assign tgt = next_dir_b;
  assign ctl = ~next_dir_b;

  // direction register
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      port_b_target_out <= 1'b0;
    end else if (clk_en_in) begin
      port_b_target_out <= next_dir_b;
    end
  end

  // target side event: spi front end or decoded target symbol
  assign tgt_ev = four_wire ? spi_ev : rx_sym[tgt];

  // requests: forward to the controller, reply on the target
  always_comb begin
    tx_req[0] = '0;
    tx_req[1] = '0;
    // RULE1 RULE6 forward unless broken
    if (tgt_ev.valid && !chain_break_enable_out) begin
      tx_req[ctl] = tgt_ev;
    end
    // RULE18 RULE19 short reply in reads
    if (tgt_ev.valid && !tgt_ev.long_sym && core_read_active_in &&
        !four_wire) begin
      tx_req[tgt] = '{1'b1, 1'b0, core_read_bit_in};
    end
  end

  // one receiver and one transmitter per port
  for (genvar p = 0; p < 2; p++) begin : g_port
    pulse_link_pkg::rx_state_t rx_st; // receiver phase
    logic [7:0] rx_cnt; // first half length
    logic rx_first_pos; // first half polarity
    pulse_link_pkg::sym_t sym; // decoded symbol pulse
    pulse_link_pkg::tx_state_t tx_st; // transmitter phase
    logic [7:0] tx_cnt; // cycles left in this half
    logic lvl_p; // positive level seen
    logic lvl_n; // negative level seen
    assign lvl_p = sync2[4 + 2 * p] & ~sync2[5 + 2 * p];
    assign lvl_n = sync2[5 + 2 * p] & ~sync2[4 + 2 * p];
    assign rx_sym[p] = sym;

    // receiver, blanked while this port drives its own pins
    always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        rx_st <= pulse_link_pkg::RX_IDLE;
        rx_cnt <= 8'h00;
        rx_first_pos <= 1'b0;
        sym <= '0;
      end else if (clk_en_in) begin
        sym <= '0;
        unique case (rx_st)
          pulse_link_pkg::RX_IDLE: begin
            if (!tx_on[p] && (lvl_p || lvl_n)) begin
              rx_first_pos <= lvl_p;
              rx_cnt <= 8'h01;
              rx_st <= pulse_link_pkg::RX_FIRST;
            end
          end
          pulse_link_pkg::RX_FIRST: begin
            if ((lvl_p && rx_first_pos) || (lvl_n && !rx_first_pos)) begin
              rx_cnt <= rx_cnt + {7'h00, rx_cnt != 8'hff};
            end else if (lvl_p || lvl_n) begin
              // RULE23 classify by first half
              sym <= '{1'b1, rx_cnt >= THRESH, rx_first_pos};
              rx_st <= pulse_link_pkg::RX_END;
            end else begin
              rx_st <= pulse_link_pkg::RX_IDLE;
            end
          end
          pulse_link_pkg::RX_END: begin
            if (!lvl_p && !lvl_n) begin
              rx_st <= pulse_link_pkg::RX_IDLE;
            end
          end
          default: begin
            rx_st <= pulse_link_pkg::RX_IDLE;
          end
        endcase
      end
    end

    // transmitter; a request while busy is dropped
    always_ff @(posedge core_clk_in or negedge rst_n) begin
      if (!rst_n) begin
        tx_st <= pulse_link_pkg::TX_OFF;
        tx_cnt <= 8'h00;
        tx_on[p] <= 1'b0;
        tx_pos[p] <= 1'b0;
        tx_neg[p] <= 1'b0;
        tx_long[p] <= 1'b0;
      end else if (clk_en_in) begin
        unique case (tx_st)
          pulse_link_pkg::TX_OFF: begin
            if (tx_req[p].valid) begin
              // RULE10 RULE13 first half
              tx_st <= pulse_link_pkg::TX_FIRST;
              tx_on[p] <= 1'b1;
              tx_pos[p] <= tx_req[p].plus;
              tx_neg[p] <= ~tx_req[p].plus;
              tx_long[p] <= tx_req[p].long_sym;
              tx_cnt <= (tx_req[p].long_sym ? LONG_HALF : SHORT_HALF) - 8'd1;
            end
          end
          pulse_link_pkg::TX_FIRST: begin
            if (tx_cnt == 8'h00) begin
              // RULE11 RULE12 equal opposite half
              tx_st <= pulse_link_pkg::TX_SECOND;
              tx_pos[p] <= tx_neg[p];
              tx_neg[p] <= tx_pos[p];
              tx_cnt <= (tx_long[p] ? LONG_HALF : SHORT_HALF) - 8'd1;
            end else begin
              tx_cnt <= tx_cnt - 8'd1;
            end
          end
          pulse_link_pkg::TX_SECOND: begin
            if (tx_cnt == 8'h00) begin
              // RULE11 return to off
              tx_st <= pulse_link_pkg::TX_OFF;
              tx_on[p] <= 1'b0;
              tx_pos[p] <= 1'b0;
              tx_neg[p] <= 1'b0;
            end else begin
              tx_cnt <= tx_cnt - 8'd1;
            end
          end
          default: begin
            tx_st <= pulse_link_pkg::TX_OFF;
            tx_on[p] <= 1'b0;
            tx_pos[p] <= 1'b0;
            tx_neg[p] <= 1'b0;
          end
        endcase
      end
    end
  end

  // pins come straight from the transmitter flops
  assign first_port_pos_pin_out = tx_pos[0];
  assign first_port_neg_pin_out = tx_neg[0];
  assign first_port_pos_pin_oe_out = tx_on[0];
  assign first_port_neg_pin_oe_out = tx_on[0];
  assign second_port_pos_pin_out = tx_pos[1];
  assign second_port_neg_pin_out = tx_neg[1];
  assign second_port_pos_pin_oe_out = tx_on[1];
  assign second_port_neg_pin_oe_out = tx_on[1];

  // break bit; only forwarding to the controller port is gated, reception and replies go on
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      chain_break_enable_out <= `BREAK_RST;
    end else if (clk_en_in) begin
      if (watchdog_reset_in) begin
        // RULE8 watchdog clears break
        chain_break_enable_out <= 1'b0;
      end else if (break_write_in) begin
        // RULE7 break leaves receive path
        chain_break_enable_out <= break_value_in;
      end
    end
  end

  // internal spi strobes rebuilt from target events
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      core_cs_n_out <= 1'b1;
      core_sck_out <= 1'b0;
      core_sdi_out <= 1'b0;
    end else if (clk_en_in) begin
      core_sck_out <= 1'b0;
      if (tgt_ev.valid && tgt_ev.long_sym) begin
        // RULE16 drive chip select
        core_cs_n_out <= tgt_ev.plus;
      end else if (tgt_ev.valid) begin
        // RULE17 set data, pulse clock
        core_sdi_out <= tgt_ev.plus;
        core_sck_out <= 1'b1;
      end
    end
  end

  // reply slot opened by each short symbol the controller sends
  assign slot_load = tx_req[ctl].valid && !tx_req[ctl].long_sym &&
                     !tx_on[ctl];
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      slot_cnt <= 8'h00;
      return_valid_out <= 1'b0;
      return_bit_out <= 1'b1;
    end else if (clk_en_in) begin
      return_valid_out <= 1'b0;
      if (slot_load) begin
        slot_cnt <= SLOT;
      end else if (slot_cnt != 8'h00) begin
        if (rx_sym[ctl].valid && !rx_sym[ctl].long_sym) begin
          return_valid_out <= 1'b1;
          return_bit_out <= rx_sym[ctl].plus;
          slot_cnt <= 8'h00;
        end else begin
          slot_cnt <= slot_cnt - 8'd1;
          if (slot_cnt == 8'h01) begin
            // RULE20 null reply reads one
            return_valid_out <= 1'b1;
            return_bit_out <= 1'b1;
          end
        end
      end
    end
  end

  // helper for checks: length of each port b symbol
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      on_len <= 8'h00;
    end else if (clk_en_in) begin
      on_len <= tx_on[1] ? on_len + 8'd1 : 8'h00;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n);

  sequence short_pos_half;
    tx_pos[1] [*7];
  endsequence
  sequence short_neg_half_off;
    tx_neg[1] [*7] ##1 !tx_on[1];
  endsequence

  AST_FOUR_WIRE_DIR: assert property (four_wire |=> !port_b_target_out) // RULE2
    else $error("four-wire mode must keep port b as controller");
  AST_DIR_REVERSE: assert property (!four_wire && core_cs_n_out && // RULE5
    rx_sym[1].valid && !rx_sym[0].valid |=> port_b_target_out)
    else $error("start on port b must make it target");
  AST_LEVELS: assert property (tx_on[0] ? (tx_pos[0] ^ tx_neg[0]) : // RULE10
    !(tx_pos[0] || tx_neg[0]))
    else $error("illegal drive level on port a");
  AST_SHORT_PAIR: assert property ($rose(tx_on[1]) && tx_pos[1] && // RULE11
    !tx_long[1] |-> short_pos_half ##1 short_neg_half_off)
    else $error("short +1 symbol shape wrong");
  AST_SYM_LEN: assert property ($fell(tx_on[1]) |-> on_len == // RULE13
    (tx_long[1] ? 8'(2 * LONG_HALF) : 8'(2 * SHORT_HALF)))
    else $error("symbol length wrong on port b");
  AST_FWD_MAP: assert property (four_wire && spi_ev.valid && // RULE15
    !chain_break_enable_out && !tx_on[1] |=> tx_on[1] &&
    tx_pos[1] == $past(spi_ev.plus) && tx_long[1] == $past(spi_ev.long_sym))
    else $error("spi event forwarded as wrong symbol");
  AST_BREAK_QUIET: assert property (chain_break_enable_out && // RULE6
    tgt_ev.valid && ctl && !tx_on[1] |=> !tx_on[1])
    else $error("controller port sent while broken");
  AST_BREAK_WDOG: assert property (watchdog_reset_in && clk_en_in // RULE8
    |=> !chain_break_enable_out)
    else $error("watchdog did not clear break bit");
  AST_CS_FROM_LONG: assert property (tgt_ev.valid && tgt_ev.long_sym // RULE16
    |=> core_cs_n_out == $past(tgt_ev.plus))
    else $error("chip select not set from long symbol");
  AST_SCK_PULSE: assert property (tgt_ev.valid && !tgt_ev.long_sym // RULE17
    |=> core_sck_out && core_sdi_out == $past(tgt_ev.plus) ##1 !core_sck_out)
    else $error("short symbol did not pulse clock once");
  AST_TGT_NO_LONG: assert property (tx_req[tgt].valid |-> // RULE19
    !tx_req[tgt].long_sym)
    else $error("target port asked to send long symbol");
  AST_NULL_ONE: assert property (slot_cnt == 8'h01 && !slot_load && // RULE20
    !rx_sym[ctl].valid |=> return_valid_out && return_bit_out)
    else $error("null reply not read as one");
endmodule

// File: pulse_link_map.svh
// constants for the two-port pulse link: timing counts and reset values
// assumes a 125 MHz core clock; all counts are derived from nanoseconds
`ifndef PULSE_LINK_MAP_SVH
`define PULSE_LINK_MAP_SVH
// core clock period
`define CLK_PERIOD_NS 8
// half-pulse widths of long and short symbols
`define LONG_HALF_NS 150
`define SHORT_HALF_NS 50
// receive split point between short and long first halves
`define CLASS_THRESH_NS 100
// time the controller waits for a reply after its own short symbol
`define REPLY_WAIT_NS 400
// least time rounded up to whole clock cycles
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LONG_HALF_CYC `CEIL_CYC(`LONG_HALF_NS)
`define SHORT_HALF_CYC `CEIL_CYC(`SHORT_HALF_NS)
`define CLASS_THRESH_CYC `CEIL_CYC(`CLASS_THRESH_NS)
`define SLOT_CYC (2 * `SHORT_HALF_CYC + `CEIL_CYC(`REPLY_WAIT_NS))
// strap level that selects the four-wire first port
`define MODE_FOUR_WIRE 1'b0
// reset value of the chain break bit
`define BREAK_RST 1'b0
`endif

// File: pulse_link_pkg.sv
// types shared by the pulse link logic
// assumes nothing of its surroundings
package pulse_link_pkg;
  // one decoded or requested symbol
  typedef struct packed {
    logic valid;
    logic long_sym;
    logic plus;
  } sym_t;
  // transmitter phases
  typedef enum logic [1:0] {
    TX_OFF = 2'b00,
    TX_FIRST = 2'b01,
    TX_SECOND = 2'b10
  } tx_state_t;
  // receiver phases
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_FIRST = 2'b01,
    RX_END = 2'b10
  } rx_state_t;
endpackage

// File: pulse_peer.sv
// far-side pulse transmitter standing on one port of the link
// assumes a one-cycle request on the core clock and an idle peer
`timescale 1ns/1ns
`include "pulse_link_map.svh"
module pulse_peer (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic long_in,
  input wire logic plus_in,
  output logic pos_out,
  output logic neg_out
);
  int cnt = 0; // cycles left in the current symbol
  int half = 1; // cycles in each half
  logic first_pos = 1'b0; // first half is the positive level
  // requests while busy are dropped, like a real neighbour
  // equal halves
  always @(posedge clk_in) begin
    if (go_in && cnt == 0) begin
      half <= long_in ? `LONG_HALF_CYC : `SHORT_HALF_CYC;
      cnt <= 2 * (long_in ? `LONG_HALF_CYC : `SHORT_HALF_CYC);
      first_pos <= plus_in;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // released pins sit at zero, the load holds them there
  // three drive states
  assign pos_out = (cnt > 0) && ((cnt > half) == first_pos);
  assign neg_out = (cnt > 0) && ((cnt > half) != first_pos);
endmodule

// File: tb_reversible_pulse_link_ports.sv
// self-checking bench for the two-port pulse link
// assumes the header constants and two pulse_peer neighbours
`timescale 1ns/1ns
`include "pulse_link_map.svh"
module tb_reversible_pulse_link_ports;
  logic clk = 1'b0, rst_n = 1'b0, strap = 1'b1;
  logic cs_n = 1'b1, sck = 1'b0, serial_data_in = 1'b0;
  logic rd_act = 1'b0, rd_bit = 1'b0, bw = 1'b0, bv = 1'b0, wd = 1'b0;
  logic go_a = 1'b0, go_b = 1'b0, lng = 1'b0, pl = 1'b0, ce = 1'b1;
  logic a_po, a_poe, a_no, a_noe, b_po, b_poe, b_no, b_noe;
  logic pa_pos, pa_neg, pb_pos, pb_neg;
  logic ccs, csck, csdi, brk, rv, rb, pbt;
  int fails = 0, checked = 0, cycles = 0;
  // drive state of each port as {pos oe, neg oe, pos, neg}
  wire [3:0] st_a = {a_poe, a_noe, a_po, a_no};
  wire [3:0] st_b = {b_poe, b_noe, b_po, b_no};
  // wire level is the sum of both parties' drives
  wire a_pos = (a_poe & a_po) | pa_pos;
  wire a_neg = (a_noe & a_no) | pa_neg;
  wire b_pos = (b_poe & b_po) | pb_pos;
  wire b_neg = (b_noe & b_no) | pb_neg;
  pulse_link_ports u_pulse_link_ports (.core_clk_in(clk),
    .resetn_in(rst_n), .clk_en_in(ce), .port_a_mode_strap_in(strap),
    .chip_select_n_in(cs_n), .spi_clk_in(sck), .serial_data_in_in(serial_data_in),
    .first_port_pos_pin_in(a_pos), .first_port_pos_pin_out(a_po),
    .first_port_pos_pin_oe_out(a_poe), .first_port_neg_pin_in(a_neg),
    .first_port_neg_pin_out(a_no), .first_port_neg_pin_oe_out(a_noe),
    .second_port_pos_pin_in(b_pos), .second_port_pos_pin_out(b_po),
    .second_port_pos_pin_oe_out(b_poe), .second_port_neg_pin_in(b_neg),
    .second_port_neg_pin_out(b_no), .second_port_neg_pin_oe_out(b_noe),
    .core_read_active_in(rd_act), .core_read_bit_in(rd_bit),
    .break_write_in(bw), .break_value_in(bv), .watchdog_reset_in(wd),
    .core_cs_n_out(ccs), .core_sck_out(csck), .core_sdi_out(csdi),
    .chain_break_enable_out(brk), .return_valid_out(rv),
    .return_bit_out(rb), .port_b_target_out(pbt));
  pulse_peer u_pulse_peer_a (.clk_in(clk), .go_in(go_a), .long_in(lng),
    .plus_in(pl), .pos_out(pa_pos), .neg_out(pa_neg));
  pulse_peer u_pulse_peer_b (.clk_in(clk), .go_in(go_b), .long_in(lng),
    .plus_in(pl), .pos_out(pb_pos), .neg_out(pb_neg));
  // core clock, 8 ns period
  initial begin
    forever #4 clk = ~clk;
  end
  // hang guard, well above the roughly one thousand cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out;
    end
  end
  // prints the counts and the verdict, then stops
  task automatic close_out;
    $display("counts: %0d checked, %0d fails", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // step past an edge so its updates have landed
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  // reset for six cycles with the given strap level
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= s;
    repeat (5) @(posedge clk);
    #1;
    chk({ccs, csck, brk, rb, pbt, st_a, st_b}, 13'h1200);
    @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // ask one peer for a symbol
  task automatic send(input logic pb, input logic l, input logic p);
    @(posedge clk);
    lng <= l;
    pl <= p;
    if (pb)
      go_b <= 1'b1;
    else
      go_a <= 1'b1;
    @(posedge clk);
    go_a <= 1'b0;
    go_b <= 1'b0;
  endtask
  // watch one design port send a whole symbol and judge it
  task automatic sym(input logic pb, input logic l, input logic p);
    int w, n1, n2;
    logic [3:0] s, f;
    w = 0;
    n1 = 0;
    n2 = 0;
    s = pb ? st_b : st_a;
    while (s[3] !== 1'b1 && w < 100) begin
      tick;
      s = pb ? st_b : st_a;
      w++;
    end
    f = s;
    chk(f, p ? 4'b1110 : 4'b1101);
    while (s === f && n1 < 60) begin
      n1++;
      tick;
      s = pb ? st_b : st_a;
    end
    f = s;
    chk(f, p ? 4'b1101 : 4'b1110);
    while (s === f && n2 < 60) begin
      n2++;
      tick;
      s = pb ? st_b : st_a;
    end
    chk(n1, l ? `LONG_HALF_CYC : `SHORT_HALF_CYC);
    chk(n2, l ? `LONG_HALF_CYC : `SHORT_HALF_CYC);
    chk(s, 4'b0000);
  endtask
  // a port that must stay silent for n cycles
  task automatic quiet(input logic pb, input int n);
    logic bad;
    bad = 1'b0;
    repeat (n) begin
      tick;
      if ((pb ? st_b : st_a) !== 4'b0000)
        bad = 1'b1;
    end
    chk(bad, 1'b0);
  endtask
  // rebuilt clock strobe and its data
  task automatic wait_sck(input logic d);
    int w;
    w = 0;
    while (csck !== 1'b1 && w < 60) begin
      tick;
      w++;
    end
    chk({csck, csdi}, {1'b1, d});
  endtask
  // resolved reply bit on the controller port
  task automatic wait_rv(input logic d);
    int w;
    w = 0;
    while (rv !== 1'b1 && w < 120) begin
      tick;
      w++;
    end
    chk({rv, rb}, {1'b1, d});
  endtask
  // one four-wire bit, data set well before the clock rise
  task automatic spi_bit(input logic d);
    @(posedge clk);
    serial_data_in <= d;
    repeat (3) @(posedge clk);
    sck <= 1'b1;
    repeat (5) @(posedge clk);
    sck <= 1'b0;
  endtask
  // four-wire first port feeding the second port
  task automatic t_spi;
    do_reset(`MODE_FOUR_WIRE);
    fork
      begin @(posedge clk); cs_n <= 1'b0; end
      sym(1'b1, 1'b1, 1'b0);
    join
    chk({ccs, pbt}, 2'b00);
    fork
      spi_bit(1'b1);
      sym(1'b1, 1'b0, 1'b1);
      wait_sck(1'b1);
    join
    wait_rv(1'b1);
    fork
      spi_bit(1'b0);
      sym(1'b1, 1'b0, 1'b0);
      wait_sck(1'b0);
    join
    send(1'b1, 1'b0, 1'b0);
    wait_rv(1'b0);
    repeat (60) tick;
    fork
      begin @(posedge clk); cs_n <= 1'b1; end
      sym(1'b1, 1'b1, 1'b1);
      quiet(1'b0, 50);
    join
    chk(ccs, 1'b1);
    $display("t_spi done");
  endtask
  // two-wire start on the first port, reads and plain writes
  task automatic t_fwd;
    do_reset(1'b1);
    fork
      send(1'b0, 1'b1, 1'b0);
      sym(1'b1, 1'b1, 1'b0);
    join
    chk({ccs, pbt}, 2'b00);
    @(posedge clk);
    rd_act <= 1'b1;
    rd_bit <= 1'b0;
    fork
      send(1'b0, 1'b0, 1'b1);
      sym(1'b0, 1'b0, 1'b0);
      sym(1'b1, 1'b0, 1'b1);
      wait_sck(1'b1);
    join
    @(posedge clk);
    rd_act <= 1'b0;
    repeat (70) tick;
    fork
      send(1'b0, 1'b0, 1'b0);
      quiet(1'b0, 40);
      sym(1'b1, 1'b0, 1'b0);
      wait_sck(1'b0);
    join
    repeat (70) tick;
    fork
      send(1'b0, 1'b1, 1'b1);
      sym(1'b1, 1'b1, 1'b1);
    join
    chk(ccs, 1'b1);
    $display("t_fwd done");
  endtask
  // two-wire start on the second port turns the chain round
  task automatic t_rev;
    do_reset(1'b1);
    fork
      send(1'b1, 1'b1, 1'b0);
      sym(1'b0, 1'b1, 1'b0);
    join
    chk({ccs, pbt}, 2'b01);
    fork
      send(1'b1, 1'b0, 1'b0);
      sym(1'b0, 1'b0, 1'b0);
      wait_sck(1'b0);
    join
    repeat (70) tick;
    fork
      send(1'b1, 1'b1, 1'b1);
      sym(1'b0, 1'b1, 1'b1);
    join
    chk({ccs, pbt}, 2'b11);
    $display("t_rev done");
  endtask
  // break bit silences the controller port only
  task automatic t_break;
    do_reset(1'b1);
    @(posedge clk);
    bw <= 1'b1;
    bv <= 1'b1;
    @(posedge clk);
    bw <= 1'b0;
    tick;
    chk(brk, 1'b1);
    fork
      send(1'b0, 1'b1, 1'b0);
      quiet(1'b1, 60);
    join
    chk(ccs, 1'b0);
    @(posedge clk);
    rd_act <= 1'b1;
    rd_bit <= 1'b1;
    fork
      send(1'b0, 1'b0, 1'b1);
      sym(1'b0, 1'b0, 1'b1);
      quiet(1'b1, 40);
    join
    // a write while the clock enable is low must not land
    @(posedge clk);
    rd_act <= 1'b0;
    ce <= 1'b0;
    bw <= 1'b1;
    bv <= 1'b0;
    @(posedge clk);
    bw <= 1'b0;
    ce <= 1'b1;
    tick;
    chk(brk, 1'b1);
    @(posedge clk);
    wd <= 1'b1;
    bw <= 1'b1;
    bv <= 1'b1;
    @(posedge clk);
    wd <= 1'b0;
    bw <= 1'b0;
    tick;
    chk(brk, 1'b0);
    $display("t_break done");
  endtask
  // main sequence
  initial begin
    t_spi;
    t_fwd;
    t_rev;
    t_break;
    close_out;
  end
endmodule
